/* File: src/rfid_rx_pkg.sv */
// Constants and carrier types of the RFID receive framer
package rfid_rx_pkg;
  localparam logic [5:0] IDX_CSC    = 6'h00;
  localparam logic [5:0] IDX_PROTO  = 6'h01;
  localparam logic [5:0] IDX_NRW    = 6'h07;
  localparam logic [5:0] IDX_RXW    = 6'h08;
  localparam logic [5:0] IDX_IRQ    = 6'h0C;
  localparam logic [5:0] IDX_COLMSK = 6'h0D;
  localparam logic [5:0] IDX_COLPOS = 6'h0E;
  localparam logic [5:0] IDX_LEVEL  = 6'h0F;
  localparam logic [5:0] IDX_CMD    = 6'h10;
  localparam logic [5:0] IDX_FCNT   = 6'h11;
  localparam logic [5:0] IDX_FIFO   = 6'h1F;

  localparam logic [7:0] CMD_FIFO_RESET = 8'h0F;
  localparam logic [7:0] CMD_RX_ENABLE  = 8'h17;
  localparam logic [7:0] CMD_RSSI_INT   = 8'h18;
  localparam logic [7:0] CMD_RSSI_EXT   = 8'h19;

  localparam int IRQ_NORESP = 0;
  localparam int IRQ_COLL   = 1;
  localparam int IRQ_FMT    = 2;
  localparam int IRQ_PAR    = 3;
  localparam int IRQ_CRC    = 4;
  localparam int IRQ_FIFO   = 5;
  localparam int IRQ_SOF    = 6;

  localparam int CSC_EXT_RSSI = 1;
  localparam int PROTO_PAR_EN = 3;
  localparam int PROTO_NO_CRC = 7;
  localparam logic [7:0] LEVEL_OSC_OK = 8'h40;

  localparam logic [7:0]  CSC_RESET    = 8'h00;
  localparam logic [7:0]  PROTO_RESET  = 8'h08;
  localparam logic [7:0]  PRE_A_RXW    = 8'h01;
  localparam logic [7:0]  PRE_A_NRW    = 8'h0E;
  localparam logic [7:0]  PRE_B_RXW    = 8'h1F;
  localparam logic [7:0]  PRE_B_NRW    = 8'h15;
  localparam logic [15:0] CRC_INIT     = 16'h6363;
  localparam logic [15:0] CRC_POLY     = 16'h8408;

  localparam int CLK_PERIOD_NS   = 5;
  localparam int RX_WAIT_STEP_NS = 9440;
  localparam int NORESP_STEP_NS  = 37760;
  localparam int RX_WAIT_STEP_CYC = RX_WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam int NORESP_STEP_CYC_DEF = NORESP_STEP_NS / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 12;

  typedef enum logic [1:0] {ST_HOLD, ST_IDLE, ST_FRAME} rx_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [2:0] main;
    logic [2:0] aux;
    logic [2:0] ext;
  } rssi_t;
endpackage

/* File: src/rfid_receive_framer.sv */
// Receive decoder, framer, FIFO, timers and signal-level latch
module rfid_receive_framer
  import rfid_rx_pkg::*;
#(
  parameter int BIT_CYC         = RX_WAIT_STEP_CYC,
  parameter int NORESP_STEP_CYC = NORESP_STEP_CYC_DEF,
  parameter int DEPTH           = FIFO_DEPTH
) (
  input  wire logic     clk_i,
  input  wire logic     reset_i,
  input  wire apb_req_t apb_i,
  output apb_rsp_t      apb_o,
  input  wire logic     subcarrier_i,
  input  wire rssi_t    rssi_i,
  input  wire logic     tx_active_i,
  input  wire logic     slot_start_i,
  output logic          rx_bit_o,
  output logic          rx_bit_clk_o,
  output logic          rx_hold_o,
  output logic          irq_o
);
  localparam int BW   = $clog2(BIT_CYC + 1);
  localparam int NW   = $clog2(NORESP_STEP_CYC + 1);
  localparam int HW   = $clog2(RX_WAIT_STEP_CYC + 1);
  localparam int CW   = $clog2(DEPTH + 1);
  localparam int PW   = $clog2(DEPTH);
  localparam logic [BW-1:0] HALF = BW'(BIT_CYC / 2);
  localparam logic [BW-1:0] THR  = BW'(BIT_CYC / 8);
  localparam logic [BW-1:0] BLAST = BW'(BIT_CYC - 1);
  localparam logic [HW-1:0] HLAST = HW'(RX_WAIT_STEP_CYC - 1);
  localparam logic [NW-1:0] NLAST = NW'(NORESP_STEP_CYC - 1);
  localparam logic [CW-1:0] WARN = CW'((DEPTH * 3) / 4);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic                     sub1;
    logic                     sub2;
    rssi_t                    rs1;
    rssi_t                    rs2;
    logic                     tx_d;
    rx_phase_t                phase;
    logic [BW-1:0]            pos;
    logic [BW-1:0]            hi1;
    logic [BW-1:0]            hi2;
    logic                     start;
    logic                     bitv;
    logic                     bit_clk;
    logic [7:0]               sh;
    logic [3:0]               nbit;
    logic [7:0]               h0;
    logic [7:0]               h1;
    logic [1:0]               nheld;
    logic [15:0]              crc;
    logic                     coll_seen;
    logic [9:0]               bidx;
    logic [DEPTH-1:0][7:0]    mem;
    logic [PW-1:0]            rd;
    logic [PW-1:0]            wr;
    logic [CW-1:0]            cnt;
    logic [7:0]               csc;
    logic [7:0]               proto;
    logic [7:0]               nrw;
    logic [7:0]               rxw;
    logic [6:0]               irqst;
    logic [5:0]               mask;
    logic [9:0]               collpos;
    logic [5:0]               lvl;
    logic [HW-1:0]            hstep;
    logic [7:0]               hrem;
    logic                     nr_run;
    logic [NW-1:0]            nstep;
    logic [7:0]               ncnt;
    apb_rsp_t                 apb;
    logic [7:0]               cap;
    logic                     fifo_ok;
    logic                     irq;
    logic                     hold;
  } state_t;

  state_t r;
  state_t next_r;
  logic [6:0] ev;
  logic       eof;
  logic       coll;
  logic       push;
  logic       pop;
  logic       acc_rd;
  logic       acc_wr;
  logic       cmd_wr;

  function automatic logic is_mapped(input logic [5:0] idx);
    unique case (idx)
      IDX_CSC, IDX_PROTO, IDX_NRW, IDX_RXW, IDX_IRQ, IDX_COLMSK,
      IDX_COLPOS, IDX_LEVEL, IDX_CMD, IDX_FCNT, IDX_FIFO: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] preset(input logic [7:0] p);
    if (p[PROTO_PAR_EN]) begin
      preset = {PRE_A_RXW, PRE_A_NRW};
    end else begin
      preset = {PRE_B_RXW, PRE_B_NRW};
    end
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    crc_byte = x;
  endfunction

  function automatic logic [2:0] max3(input logic [2:0] a, input logic [2:0] b);
    max3 = (a > b) ? a : b;
  endfunction

  always_comb begin
    logic       m1;
    logic       m2;
    logic       done;
    logic       par_on;
    logic       crc_on;
    logic [7:0] b;
    logic [7:0] pdat;
    logic [7:0] rdv;
    logic [5:0] idx;
    m1 = 1'b0;
    m2 = 1'b0;
    done = 1'b0;
    b = '0;
    pdat = '0;
    rdv = '0;
    idx = apb_i.paddr[7:2];
    par_on = r.proto[PROTO_PAR_EN];
    crc_on = !r.proto[PROTO_NO_CRC];
    next_r = r;
    ev = '0;
    eof = 1'b0;
    coll = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    next_r.sub1 = subcarrier_i;
    next_r.sub2 = r.sub1;
    next_r.rs1 = rssi_i;
    next_r.rs2 = r.rs1;
    next_r.tx_d = tx_active_i;
    next_r.bit_clk = 1'b0;

    unique case (r.phase)
      ST_HOLD: begin
        if (r.hrem == '0) begin
          next_r.phase = ST_IDLE;
        end else if (r.hstep == HLAST) begin
          next_r.hstep = '0;
          next_r.hrem = r.hrem - 8'h01;
        end else begin
          next_r.hstep = r.hstep + 1'b1;
        end
      end
      ST_IDLE: begin
        if (r.sub2) begin
          next_r.phase = ST_FRAME;
          next_r.pos = '0;
          next_r.hi1 = '0;
          next_r.hi2 = '0;
          next_r.start = 1'b1;
          next_r.bidx = '0;
          next_r.nbit = '0;
          next_r.nheld = '0;
          next_r.crc = CRC_INIT;
          next_r.coll_seen = 1'b0;
        end
      end
      ST_FRAME: begin
        if (r.pos < HALF) begin
          next_r.hi1 = r.hi1 + BW'(r.sub2);
        end else begin
          next_r.hi2 = r.hi2 + BW'(r.sub2);
        end
        next_r.pos = r.pos + 1'b1;
        if (r.pos == BLAST) begin
          // Each half counts as modulated when more than an eighth of a bit period reads high
          m1 = r.hi1 > THR;
          m2 = r.hi2 > THR;
          next_r.pos = '0;
          next_r.hi1 = '0;
          next_r.hi2 = '0;
          if (r.start) begin
            if (m1 && !m2) begin
              next_r.start = 1'b0;
              ev[IRQ_SOF] = 1'b1;
              next_r.nr_run = 1'b0;
            end else begin
              next_r.phase = ST_IDLE;
            end
          end else if (!m1 && !m2) begin
            next_r.phase = ST_IDLE;
            eof = 1'b1;
            if (r.nbit != '0 || (crc_on && r.nheld == 2'd1)) begin
              ev[IRQ_FMT] = 1'b1;
            end
            if (crc_on && r.nheld == 2'd2 && r.crc != {r.h1, r.h0}) begin
              ev[IRQ_CRC] = 1'b1;
            end
          end else begin
            next_r.bitv = m1;
            next_r.bit_clk = 1'b1;
            next_r.bidx = r.bidx + 10'd1;
            if (m1 && m2 && !r.coll_seen) begin
              coll = 1'b1;
              next_r.coll_seen = 1'b1;
              next_r.collpos = r.bidx;
            end
            if (r.nbit == 4'd8) begin
              done = 1'b1;
              b = r.sh;
              if (!(^{r.sh, m1})) begin
                ev[IRQ_PAR] = 1'b1;
              end
            end else begin
              next_r.sh = {m1, r.sh[7:1]};
              next_r.nbit = r.nbit + 4'd1;
              if (r.nbit == 4'd7 && !par_on) begin
                done = 1'b1;
                b = {m1, r.sh[7:1]};
              end
            end
          end
        end
      end
    endcase

    if (done) begin
      next_r.nbit = '0;
      if (!crc_on) begin
        push = 1'b1;
        pdat = b;
      end else if (r.nheld == 2'd2) begin
        // Last two bytes are held back so the CRC never lands in the FIFO
        push = 1'b1;
        pdat = r.h0;
        next_r.crc = crc_byte(r.crc, r.h0);
        next_r.h0 = r.h1;
        next_r.h1 = b;
      end else if (r.nheld == 2'd1) begin
        next_r.h1 = b;
        next_r.nheld = 2'd2;
      end else begin
        next_r.h0 = b;
        next_r.nheld = 2'd1;
      end
    end

    if (tx_active_i) begin
      next_r.phase = ST_HOLD;
      next_r.hrem = r.rxw;
      next_r.hstep = '0;
    end

    // No-response timer
    if (slot_start_i && r.nrw != '0) begin
      next_r.nr_run = 1'b1;
      next_r.nstep = '0;
      next_r.ncnt = '0;
    end else if (r.nr_run && !ev[IRQ_SOF]) begin
      if (r.ncnt == r.nrw) begin
        next_r.nr_run = 1'b0;
        ev[IRQ_NORESP] = 1'b1;
      end else if (r.nstep == NLAST) begin
        next_r.nstep = '0;
        next_r.ncnt = r.ncnt + 8'h01;
      end else begin
        next_r.nstep = r.nstep + 1'b1;
      end
    end

    // Register read data, captured in the setup phase
    unique case (idx)
      IDX_CSC:    rdv = r.csc;
      IDX_PROTO:  rdv = r.proto;
      IDX_NRW:    rdv = r.nrw;
      IDX_RXW:    rdv = r.rxw;
      IDX_IRQ:    rdv = {1'b0, r.irqst};
      IDX_COLMSK: rdv = {r.collpos[9:8], r.mask};
      IDX_COLPOS: rdv = r.collpos[7:0];
      IDX_LEVEL:  rdv = LEVEL_OSC_OK | {2'b00, r.lvl};
      IDX_FCNT:   rdv = 8'(r.cnt);
      IDX_FIFO:   rdv = (r.cnt != '0) ? r.mem[r.rd] : '0;
      default:    rdv = '0;
    endcase
    next_r.apb.pready = 1'b0;
    if (apb_i.psel && !apb_i.penable) begin
      next_r.apb.pready = 1'b1;
      next_r.apb.pslverr = !is_mapped(idx);
      next_r.apb.prdata = {24'h00_0000, rdv};
      next_r.cap = rdv;
      next_r.fifo_ok = (idx == IDX_FIFO) && (r.cnt != '0);
    end
    acc_rd = apb_i.psel && apb_i.penable && r.apb.pready && !apb_i.pwrite;
    acc_wr = apb_i.psel && apb_i.penable && r.apb.pready && apb_i.pwrite;
    cmd_wr = acc_wr && idx == IDX_CMD;

    if (acc_rd && idx == IDX_IRQ) begin
      next_r.irqst = r.irqst & ~r.cap[6:0];
      next_r.irq = 1'b0;
    end
    if (acc_rd && idx == IDX_LEVEL) begin
      next_r.lvl = r.lvl & ~r.cap[5:0];
    end
    if (acc_rd && idx == IDX_FIFO && r.fifo_ok) begin
      pop = 1'b1;
      next_r.rd = (r.rd == PLAST) ? '0 : r.rd + 1'b1;
    end
    if (!r.tx_d && tx_active_i) begin
      next_r.lvl = '0;
    end
    // A transmit start wins, so the clear is not undone by the peak update
    if (r.phase == ST_FRAME && !tx_active_i) begin
      if (r.csc[CSC_EXT_RSSI]) begin
        next_r.lvl[2:0] = max3(next_r.lvl[2:0], r.rs2.ext);
      end else begin
        next_r.lvl[2:0] = max3(next_r.lvl[2:0], r.rs2.main);
        next_r.lvl[5:3] = max3(next_r.lvl[5:3], r.rs2.aux);
      end
    end

    if (acc_wr) begin
      unique case (idx)
        IDX_CSC:    next_r.csc = apb_i.pwdata[7:0];
        IDX_PROTO: begin
          next_r.proto = apb_i.pwdata[7:0];
          {next_r.rxw, next_r.nrw} = preset(apb_i.pwdata[7:0]);
        end
        IDX_NRW:    next_r.nrw = apb_i.pwdata[7:0];
        IDX_RXW:    next_r.rxw = apb_i.pwdata[7:0];
        IDX_COLMSK: next_r.mask = apb_i.pwdata[5:0];
        IDX_CMD: begin
          unique case (apb_i.pwdata[7:0])
            CMD_RX_ENABLE: begin
              if (r.phase == ST_HOLD && !tx_active_i) begin
                next_r.phase = ST_IDLE;
              end
            end
            CMD_RSSI_INT: next_r.lvl = {r.rs2.aux, r.rs2.main};
            CMD_RSSI_EXT: next_r.lvl = {3'b000, r.rs2.ext};
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    if (push) begin
      if (r.cnt == FULL && !pop) begin
        ev[IRQ_FMT] = 1'b1;
      end else begin
        next_r.mem[r.wr] = pdat;
        next_r.wr = (r.wr == PLAST) ? '0 : r.wr + 1'b1;
        if (r.cnt + CW'(1) == WARN && !pop) begin
          ev[IRQ_FIFO] = 1'b1;
        end
      end
    end
    next_r.cnt = r.cnt + CW'(push && !(r.cnt == FULL && !pop)) - CW'(pop);
    if (cmd_wr && apb_i.pwdata[7:0] == CMD_FIFO_RESET) begin
      next_r.rd = '0;
      next_r.wr = '0;
      next_r.cnt = '0;
    end

    // Flags set by hardware win over a clear in the same cycle
    next_r.irqst = next_r.irqst | ev;
    next_r.irqst[IRQ_COLL] = next_r.irqst[IRQ_COLL] | coll;
    if (eof || coll || |(ev[5:0] & ~r.mask)) begin
      next_r.irq = 1'b1;
    end
    next_r.hold = (next_r.phase == ST_HOLD);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.phase <= ST_IDLE;
      r.csc <= CSC_RESET;
      r.proto <= PROTO_RESET;
      {r.rxw, r.nrw} <= {PRE_A_RXW, PRE_A_NRW};
    end else begin
      r <= next_r;
    end
  end

  assign apb_o = r.apb;
  assign rx_bit_o = r.bitv;
  assign rx_bit_clk_o = r.bit_clk;
  assign rx_hold_o = r.hold;
  assign irq_o = r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence setup_s(logic [5:0] a);
    apb_i.psel && !apb_i.penable && apb_i.paddr[7:2] == a && !apb_i.pwrite;
  endsequence
  sequence access_s;
    apb_i.psel && apb_i.penable && r.apb.pready;
  endsequence

  fifo_bound_a: assert property (r.cnt <= FULL)
    else $error("fifo count above depth");
  fifo_pop_a: assert property (setup_s(IDX_FIFO) ##1
    (access_s and (r.fifo_ok && !push)) |=> r.cnt == $past(r.cnt) - CW'(1))
    else $error("fifo read did not drop count");
  hold_after_tx_a: assert property ($fell(tx_active_i) && r.rxw != '0
    |-> r.phase == ST_HOLD ##1 r.phase == ST_HOLD)
    else $error("decoder not held after transmit");
  sof_flag_a: assert property (ev[IRQ_SOF] |=> r.irqst[IRQ_SOF])
    else $error("start of frame flag missing");
  eof_irq_a: assert property (eof |=> irq_o)
    else $error("no interrupt at end of reception");
  fifo_level_a: assert property (r.cnt == WARN && $past(r.cnt) == WARN - CW'(1)
    |-> r.irqst[IRQ_FIFO])
    else $error("fifo level flag missing");
  error_irq_a: assert property (|(ev[IRQ_CRC:IRQ_FMT] & ~r.mask[IRQ_CRC:IRQ_FMT])
    |=> irq_o && |r.irqst[IRQ_CRC:IRQ_FMT])
    else $error("frame error not reported");
  proto_preset_a: assert property (acc_wr && apb_i.paddr[7:2] == IDX_PROTO
    |=> r.rxw == (r.proto[PROTO_PAR_EN] ? PRE_A_RXW : PRE_B_RXW)
    && r.nrw == (r.proto[PROTO_PAR_EN] ? PRE_A_NRW : PRE_B_NRW))
    else $error("presets not reloaded");
  coll_pos_a: assert property (coll |=> r.irqst[IRQ_COLL] && irq_o
    && r.collpos == $past(r.bidx))
    else $error("collision not recorded");
  noresp_flag_a: assert property (ev[IRQ_NORESP]
    |=> r.irqst[IRQ_NORESP] && !r.nr_run)
    else $error("no-response flag missing");
  level_clear_a: assert property ($rose(tx_active_i) && !cmd_wr |=> r.lvl == '0)
    else $error("level not cleared at transmit");
endmodule

/* File: tb/host_apb_model.sv */
// Host-side APB master model issuing single register transfers
module host_apb_model
  import rfid_rx_pkg::*;
(
  input  wire logic     clk_i,
  output apb_req_t      apb_o,
  input  wire apb_rsp_t apb_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs;
  initial begin
    apb_o = '0;
    hangs = 0;
  end
  // Request held until pready is seen at a rising edge or 64 edges pass, then released
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    int i;
    @(posedge clk_i);
    apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
               pwdata: {24'h00_0000, wd}};
    @(posedge clk_i);
    apb_o.penable <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_i);
      if (apb_i.pready === 1'b1) break;
    end
    if (i == 64) hangs++;
    rd = apb_i.prdata[7:0];
    err = apb_i.pslverr;
    apb_o <= '0;
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the RFID receive framer
module testbench;
  import rfid_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 32;
  localparam int NS = 20;
  logic        clk_i;
  logic        reset_i;
  logic        subcarrier_i;
  logic        tx_active_i;
  logic        slot_start_i;
  rssi_t       rssi_i;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  logic        rx_bit_o;
  logic        rx_bit_clk_o;
  logic        rx_hold_o;
  logic        irq_o;
  int          error_cnt;
  int          n_compared;
  logic [15:0] lf;
  logic [7:0]  fb [12];
  logic [7:0]  v;
  logic        e;
  int          n;
  int          k;
  int          nclk = 0;

  rfid_receive_framer #(.BIT_CYC(BC), .NORESP_STEP_CYC(NS), .DEPTH(FIFO_DEPTH)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_req), .apb_o(apb_rsp),
    .subcarrier_i(subcarrier_i), .rssi_i(rssi_i), .tx_active_i(tx_active_i),
    .slot_start_i(slot_start_i), .rx_bit_o(rx_bit_o), .rx_bit_clk_o(rx_bit_clk_o),
    .rx_hold_o(rx_hold_o), .irq_o(irq_o));

  host_apb_model u_host (.clk_i(clk_i), .apb_o(apb_req), .apb_i(apb_rsp));

  // Counts decoded-bit strobes for the bit clock check
  always @(posedge clk_i) begin
    if (rx_bit_clk_o === 1'b1) begin
      nclk <= nclk + 1;
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic odd_par(input logic [7:0] b);
    return ~^b;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       er;
    u_host.xfer(1'b1, idx, d, r, er);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] d);
    logic er;
    u_host.xfer(1'b0, idx, 8'h00, d, er);
  endtask

  // One bit period: a marks the first half, b the second
  task automatic half2(input logic a, input logic b);
    subcarrier_i <= a;
    repeat (BC / 2) @(posedge clk_i);
    subcarrier_i <= b;
    repeat (BC / 2) @(posedge clk_i);
  endtask

  // Bit cb of the frame (parity bits counted) is sent with both halves modulated
  task automatic send_frame(input int cnt, input logic bad, input int cb);
    logic p;
    logic c;
    half2(1'b1, 1'b0);
    for (int i = 0; i < cnt; i++) begin
      for (int b = 0; b < 8; b++) begin
        c = (i * 9 + b == cb);
        half2(fb[i][b] | c, !fb[i][b] | c);
      end
      p = odd_par(fb[i]) ^ bad;
      half2(p, !p);
    end
    half2(1'b0, 1'b0);
  endtask

  task automatic wait_irq();
    int i;
    for (i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
    chk(irq_o, 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1;
    subcarrier_i = 1'b0;
    tx_active_i = 1'b0;
    slot_start_i = 1'b0;
    rssi_i = '0;
    error_cnt = 0;
    n_compared = 0;
    lf = 16'h0D95;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(IDX_CSC, v);    chk(v, CSC_RESET);
    rd(IDX_PROTO, v);  chk(v, PROTO_RESET);
    rd(IDX_RXW, v);    chk(v, PRE_A_RXW);
    rd(IDX_NRW, v);    chk(v, PRE_A_NRW);
    u_host.xfer(1'b0, 6'h02, 8'h00, v, e);
    chk(e, 1'b1);
    chk(v, 8'h00);
    wr(IDX_PROTO, 8'h00);
    rd(IDX_RXW, v);    chk(v, PRE_B_RXW);
    rd(IDX_NRW, v);    chk(v, PRE_B_NRW);
    wr(IDX_RXW, 8'h05);
    wr(IDX_PROTO, 8'h88);
    rd(IDX_RXW, v);    chk(v, PRE_A_RXW);
    wr(IDX_NRW, 8'h02);
    rd(IDX_NRW, v);    chk(v, 8'h02);
    // Receive wait after a transmit burst
    tx_active_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    tx_active_i <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 3000 && rx_hold_o === 1'b1; k++) @(posedge clk_i);
    chk(k >= RX_WAIT_STEP_CYC && k <= RX_WAIT_STEP_CYC + 2, 1'b1);
    // Long frame crossing the three-quarter level, level pin masked
    wr(IDX_COLMSK, 8'h20);
    lf = lfsr_next(lf);
    n = 9 + lf % 3;
    for (int i = 0; i < n; i++) begin
      lf = lfsr_next(lf);
      fb[i] = lf[7:0];
    end
    k = nclk;
    send_frame(n, 1'b0, -1);
    chk(nclk - k, n * 9);
    chk(rx_bit_o, odd_par(fb[n - 1]));
    wait_irq();
    rd(IDX_FCNT, v);   chk(v, n[7:0]);
    rd(IDX_IRQ, v);    chk(v & 8'h60, 8'h60);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    for (int i = 0; i < n; i++) begin
      rd(IDX_FIFO, v); chk(v, fb[i]);
    end
    rd(IDX_FCNT, v);   chk(v, 8'h00);
    // Corrupted parity in a one-byte frame
    send_frame(1, 1'b1, -1);
    wait_irq();
    rd(IDX_IRQ, v);    chk(v[IRQ_PAR], 1'b1);
    // Collision in the third bit of a one-byte frame
    fb[0] = 8'h04;
    send_frame(1, 1'b0, 2);
    wait_irq();
    rd(IDX_IRQ, v);    chk(v[IRQ_COLL], 1'b1);
    rd(IDX_COLPOS, v); chk(v, 8'h02);
    rd(IDX_COLMSK, v); chk(v, 8'h20);
    wr(IDX_CMD, CMD_FIFO_RESET);
    rd(IDX_FCNT, v);   chk(v, 8'h00);
    // Empty slot timing with a wait of two steps
    slot_start_i <= 1'b1;
    @(posedge clk_i);
    slot_start_i <= 1'b0;
    repeat (25) @(posedge clk_i);
    rd(IDX_IRQ, v);    chk(v[IRQ_NORESP], 1'b0);
    repeat (30) @(posedge clk_i);
    rd(IDX_IRQ, v);    chk(v[IRQ_NORESP], 1'b1);
    // Level measurements, internal then external
    lf = lfsr_next(lf);
    rssi_i <= '{main: lf[2:0], aux: lf[5:3], ext: lf[8:6]};
    repeat (4) @(posedge clk_i);
    wr(IDX_CSC, 8'h20);
    wr(IDX_CMD, CMD_RX_ENABLE);
    wr(IDX_CMD, CMD_RSSI_INT);
    rd(IDX_LEVEL, v);  chk(v, LEVEL_OSC_OK | {2'b00, lf[5:0]});
    rd(IDX_LEVEL, v);  chk(v, LEVEL_OSC_OK);
    wr(IDX_CSC, 8'h22);
    wr(IDX_CMD, CMD_RSSI_EXT);
    rd(IDX_LEVEL, v);  chk(v[2:0], lf[8:6]);
    chk(u_host.hangs, 0);
    tally_and_finish();
  end
endmodule
